/* File: uart_tx_rx_core_tb_top.sv */
// Testbench for the serial channel: bus tasks, scenarios, verdict.
// Assumes the reset divisor of 8 (16 clocks a bit) and the peer model.
`default_nettype none
module uart_tx_rx_core_tb_top
  import utr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_b, last_r;
  logic [3:0] s_axi_wstrb;
  logic serial_in_pin, serial_out_pin, tx_done_irq, rx_done_irq, rx_error_irq;
  int error_cnt, checked, txn, rxn, ern, cyc, r0, e0;
  utr_core DUT (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_in_pin, .serial_out_pin,
    .tx_done_irq, .rx_done_irq, .rx_error_irq);
  utr_peer #(.BIT(16)) peer (.clk, .line_in(serial_out_pin), .line_out(serial_in_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Event counts and the run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    txn <= txn + int'(tx_done_irq);
    rxn <= rxn + int'(rx_done_irq);
    ern <= ern + int'(rx_error_irq);
    if (cyc == 40000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Ready outputs may rise before valid, so each valid drops only when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    last_b = s_axi_bresp;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    last_r = s_axi_rresp;
    chk(n, e, s_axi_rdata);
  endtask
  task automatic rx_chk(input logic [7:0] b, input logic [2:0] st, input int dr, input int de);
    chk("rx_irqs", r0 + dr, rxn);
    chk("err_irqs", e0 + de, ern);
    rdc(UTR_RX_ERR_OFS, {29'h0, st}, "rx_err");
    rdc(UTR_RX_BUF_OFS, {24'h0, b}, "rx_buf");
    r0 = rxn;
    e0 = ern;
  endtask
  task automatic t_regs();
    rdc(UTR_MODE_OFS, 32'h01, "mode");
    rdc(UTR_RX_BUF_OFS, 32'hff, "rx_buf");
    rdc(8'h20, 32'h0, "unmapped");
    chk("rresp", {30'h0, UTR_RESP_SLVERR}, {30'h0, last_r});
    wr(8'h20, 32'h0);
    chk("bresp", {30'h0, UTR_RESP_SLVERR}, {30'h0, last_b});
    wr(UTR_DIV_OFS, 32'h3);
    rdc(UTR_DIV_OFS, 32'h8, "divisor");
  endtask
  // Two bytes back to back in every parity mode
  task automatic t_tx();
    logic [7:0] b [2] = '{8'h07, 8'h5a};
    logic [1:0] pm;
    logic [8:0] f;
    logic e;
    for (int k = 0; k < 4; k++) begin
      pm = 2'(k);
      wr(UTR_MODE_OFS, {24'h0, 8'hc4 | {3'h0, pm, 3'h0}});
      wr(UTR_TX_BUF_OFS, {24'h0, b[0]});
      rdc(UTR_TX_STATUS_OFS, 32'h1, "tx_status");
      wr(UTR_TX_BUF_OFS, {24'h0, b[1]});
      rdc(UTR_TX_STATUS_OFS, 32'h3, "tx_status");
      repeat (500) @(posedge clk);
      rdc(UTR_TX_STATUS_OFS, 32'h0, "tx_status");
      chk("tx_irqs", 2 * k + 2, txn);
      chk("tx_frames", 2, peer.rxq.size());
      for (int j = 0; j < 2; j++) begin
        f = peer.rxq.pop_front();
        e = (pm == UTR_PAR_NONE) ? 1'b1 : peer.pbit(b[j], pm);
        chk("tx_data", {24'h0, b[j]}, {24'h0, f[7:0]});
        chk("tx_bit8", {31'h0, e}, {31'h0, f[8]});
      end
    end
  endtask
  // Writes while disabled, then enable cleared mid-frame
  task automatic t_tx_off();
    wr(UTR_MODE_OFS, 32'h84);
    wr(UTR_TX_BUF_OFS, 32'h55);
    repeat (300) @(posedge clk);
    rdc(UTR_TX_STATUS_OFS, 32'h0, "tx_status");
    chk("tx_irqs", 8, txn);
    wr(UTR_MODE_OFS, 32'hc4);
    wr(UTR_TX_BUF_OFS, 32'h55);
    repeat (40) @(posedge clk);
    wr(UTR_MODE_OFS, 32'h84);
    rdc(UTR_TX_STATUS_OFS, 32'h0, "tx_status");
    repeat (300) @(posedge clk);
    chk("tx_line", 32'h1, {31'h0, serial_out_pin});
    wr(UTR_MODE_OFS, 32'hc6);
    wr(UTR_TX_BUF_OFS, 32'h5a);
    repeat (170) @(posedge clk);
    chk("tx_irqs", 8, txn);
    repeat (30) @(posedge clk);
    chk("tx_irqs", 9, txn);
    peer.rxq.delete();
  endtask
  // Zero parity gets a wrong parity bit, which must pass unchecked
  task automatic t_rx();
    for (int k = 0; k < 4; k++) begin
      wr(UTR_MODE_OFS, {24'h0, 8'ha4 | {3'h0, 2'(k), 3'h0}});
      peer.send(8'ha5, 2'(k), 8, k == 1, 1'b0);
      rx_chk(8'ha5, 3'h0, 1, 0);
    end
  endtask
  task automatic t_rx_err();
    wr(UTR_MODE_OFS, 32'hbc);
    peer.send(8'hc3, UTR_PAR_EVEN, 8, 1'b1, 1'b0);
    rx_chk(8'hc3, 3'h4, 0, 1);
    rdc(UTR_RX_ERR_OFS, 32'h0, "rx_err");
    wr(UTR_MODE_OFS, 32'hbd);
    peer.send(8'h3c, UTR_PAR_EVEN, 8, 1'b0, 1'b1);
    rx_chk(8'h3c, 3'h2, 1, 0);
    peer.send(8'h11, UTR_PAR_EVEN, 8, 1'b0, 1'b0);
    peer.send(8'h22, UTR_PAR_EVEN, 8, 1'b0, 1'b0);
    rx_chk(8'h11, 3'h1, 2, 0);
    wr(UTR_MODE_OFS, 32'ha0);
    peer.send(8'hff, UTR_PAR_NONE, 7, 1'b0, 1'b0);
    rx_chk(8'h7f, 3'h0, 1, 0);
    wr(UTR_MODE_OFS, 32'h80);
    peer.send(8'h0f, UTR_PAR_NONE, 7, 1'b0, 1'b0);
    rx_chk(8'h7f, 3'h0, 0, 0);
    wr(UTR_MODE_OFS, 32'hbc);
    fork
      peer.send(8'h0f, UTR_PAR_EVEN, 8, 1'b1, 1'b0);
      begin
        repeat (80) @(posedge clk);
        wr(UTR_MODE_OFS, 32'h9c);
      end
    join
    rx_chk(8'h7f, 3'h0, 0, 0);
    wr(UTR_MODE_OFS, 32'ha4);
    peer.glitch();
    repeat (300) @(posedge clk);
    rx_chk(8'h7f, 3'h0, 0, 0);
  endtask
  initial begin
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_tx();
    t_tx_off();
    t_rx();
    t_rx_err();
    finish_test();
  end
endmodule // uart_tx_rx_core_tb_top
`default_nettype wire

/* File: utr_core.sv */
// Asynchronous serial transceiver channel with AXI4-Lite register slave.
// Assumes one clock, asynchronous active-low reset, peer at matching baud.
// Functional notes
// RULE_01 - Software polls buffer-full before next write
// RULE_02 - Shift-active reads 0 after full completion
// RULE_03 - Shift-active reads 1 while frame shifts
// RULE_04 - Software checks shift-active before transmitter init
// RULE_05 - Write sets full, loads shifter, sets active
// RULE_06 - Last frame done: irq, both flags zero
// RULE_07 - Clearing unit or tx enable resets transmitter
// RULE_08 - Receiver hunts start bit at baud rate; the idle receiver checks the filtered line every clock instead
// RULE_09 - Receive disabled: idle, buffer kept, no irq
// RULE_10 - Stop bit: completion irq and buffer copy
// RULE_11 - Overrun: no copy, flag, selected irq
// RULE_12 - Parity/framing error: still copy, selected irq
// RULE_13 - Receive disable mid-frame aborts silently
// RULE_14 - Errors set at completion, merge select irq
// RULE_15 - Reading error status clears all flags
// RULE_16 - Parity, framing, overrun error causes
// RULE_17 - Even parity generate and check
// RULE_18 - Odd parity generate and check
// RULE_19 - Zero parity sends 0, never checks
// RULE_20 - No parity: no bit, no error
// RULE_21 - Two equal samples change filtered input
// RULE_22 - Filter delays receive up to two clocks
// RULE_23 - LSB first, start, data, parity, stop
// RULE_24 - Seven-bit data: bit 7 reads 0
// RULE_25 - Tx irq at last stop bit output
// RULE_26 - Tx disabled ignores buffer writes
`default_nettype none
module utr_core
  import utr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial line
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  // Interrupt pulses
  output logic tx_done_irq,
  output logic rx_done_irq,
  output logic rx_error_irq
);

  // Register state
  logic [7:0] serial_mode_control_reg;
  logic [7:0] div_reg;
  logic [7:0] tx_holding_buffer_reg;
  logic tx_buffer_full_flag_reg;
  logic tx_shift_active_flag_reg;
  logic [7:0] rx_holding_buffer_reg;
  logic rx_unread_reg;
  logic parity_error_flag_reg, framing_error_flag_reg, overrun_error_flag_reg;

  // Mode fields
  wire unit_enable_bit = serial_mode_control_reg[UTR_MODE_UNIT_EN];
  wire transmit_enable_bit = serial_mode_control_reg[UTR_MODE_TX_EN];
  wire receive_enable_bit = serial_mode_control_reg[UTR_MODE_RX_EN];
  wire [1:0] par_mode = serial_mode_control_reg[UTR_MODE_PAR_LO +: 2];
  wire len8 = serial_mode_control_reg[UTR_MODE_LEN8];
  wire stop2 = serial_mode_control_reg[UTR_MODE_STOP2];
  wire error_irq_merge_select = serial_mode_control_reg[UTR_MODE_MERGE];
  wire tx_run = unit_enable_bit & transmit_enable_bit;
  wire rx_run = unit_enable_bit & receive_enable_bit;
  wire [2:0] last_bit = len8 ? 3'h7 : 3'h6;
  wire has_par = (par_mode != UTR_PAR_NONE);
  wire [8:0] bit_ticks = {div_reg, 1'b0};
  wire [8:0] half_ticks = {1'b0, div_reg};

  // AXI handshake state
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  wire wr_lane0 = wr_fire & w_strb_reg[0];
  wire wr_mode = wr_lane0 & (aw_addr_reg == UTR_MODE_OFS);
  wire wr_txb = wr_lane0 & (aw_addr_reg == UTR_TX_BUF_OFS);
  wire wr_div = wr_lane0 & (aw_addr_reg == UTR_DIV_OFS);
  wire wr_known = (aw_addr_reg == UTR_MODE_OFS) | (aw_addr_reg == UTR_TX_BUF_OFS) |
                  (aw_addr_reg == UTR_DIV_OFS);
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rd_err = ar_take & (s_axi_araddr == UTR_RX_ERR_OFS);
  wire rd_rxb = ar_take & (s_axi_araddr == UTR_RX_BUF_OFS);
  wire rd_known = (s_axi_araddr <= UTR_IRQ_OFS) & (s_axi_araddr[1:0] == 2'h0);
  logic [31:0] rd_mux;
  always_comb begin
    unique case (s_axi_araddr)
      UTR_MODE_OFS: rd_mux = {24'h0, serial_mode_control_reg};
      UTR_TX_STATUS_OFS: rd_mux = {30'h0, tx_buffer_full_flag_reg, tx_shift_active_flag_reg};
      UTR_RX_ERR_OFS: rd_mux = {29'h0, parity_error_flag_reg, framing_error_flag_reg,
                                overrun_error_flag_reg};
      UTR_TX_BUF_OFS: rd_mux = {24'h0, tx_holding_buffer_reg};
      UTR_RX_BUF_OFS: rd_mux = {24'h0, rx_holding_buffer_reg};
      UTR_DIV_OFS: rd_mux = {24'h0, div_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= UTR_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? UTR_RESP_OKAY : UTR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_hold_reg;
  assign s_axi_wready = ~w_hold_reg;

  // Read channel: one cycle to answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= UTR_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_known ? UTR_RESP_OKAY : UTR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = ~s_axi_rvalid;

  // Mode and divisor; divisor below minimum clamps to keep timing sane
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_mode_control_reg <= UTR_MODE_RST;
      div_reg <= UTR_DIV_RST;
    end else begin
      if (wr_mode) serial_mode_control_reg <= w_data_reg[7:0];
      if (wr_div) div_reg <= (w_data_reg[7:0] < 8'(UTR_DIV_MIN)) ? 8'(UTR_DIV_MIN)
                                                                 : w_data_reg[7:0];
    end
  end

  // Transmitter
  utr_phase_type tx_phase_reg;
  logic [8:0] tx_tick_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic tx_par_reg, tx_stop_cnt_reg;
  wire tx_tick_end = (tx_tick_reg == bit_ticks - 9'h1);
  // RULE_17 even parity bit
  // RULE_18 odd parity bit
  // RULE_19 zero parity bit
  wire tx_par_bit = (par_mode == UTR_PAR_EVEN) ? ^(tx_holding_buffer_reg & {len8, 7'h7f}) :
                    (par_mode == UTR_PAR_ODD) ? ~^(tx_holding_buffer_reg & {len8, 7'h7f}) :
                    1'b0;
  wire tx_load = tx_buffer_full_flag_reg & (tx_phase_reg == UTR_IDLE);
  // RULE_25 irq at last stop
  wire tx_last_stop = (tx_phase_reg == UTR_STOP) & tx_tick_end & (tx_stop_cnt_reg == stop2);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_phase_reg <= UTR_IDLE;
      tx_tick_reg <= 9'h0;
      tx_bit_reg <= 3'h0;
      tx_shift_reg <= 8'h0;
      tx_par_reg <= 1'b0;
      tx_stop_cnt_reg <= 1'b0;
      tx_holding_buffer_reg <= 8'h0;
      tx_buffer_full_flag_reg <= 1'b0;
      tx_shift_active_flag_reg <= 1'b0;
      serial_out_pin <= 1'b1;
      tx_done_irq <= 1'b0;
    end else if (!tx_run) begin
      // RULE_07 transmitter initialised
      tx_phase_reg <= UTR_IDLE;
      tx_tick_reg <= 9'h0;
      tx_buffer_full_flag_reg <= 1'b0;
      tx_shift_active_flag_reg <= 1'b0;
      tx_done_irq <= 1'b0;
      serial_out_pin <= 1'b1;
      // RULE_26 write ignored when disabled
    end else begin
      tx_done_irq <= 1'b0;
      // RULE_05 write marks buffer full
      if (wr_txb) begin
        tx_holding_buffer_reg <= w_data_reg[7:0];
        tx_buffer_full_flag_reg <= 1'b1;
      end
      tx_tick_reg <= tx_tick_end ? 9'h0 : tx_tick_reg + 9'h1;
      unique case (tx_phase_reg)
        UTR_IDLE: begin
          tx_tick_reg <= 9'h0;
          // RULE_05 buffer moves to shifter
          // RULE_03 active while shifting
          if (tx_load) begin
            tx_shift_reg <= tx_holding_buffer_reg;
            tx_par_reg <= tx_par_bit;
            tx_buffer_full_flag_reg <= wr_txb;
            tx_shift_active_flag_reg <= 1'b1;
            tx_phase_reg <= UTR_START;
            serial_out_pin <= 1'b0;
          end
        end
        UTR_START: if (tx_tick_end) begin
          // RULE_23 LSB first
          tx_phase_reg <= UTR_DATA;
          tx_bit_reg <= 3'h0;
          serial_out_pin <= tx_shift_reg[0];
        end
        UTR_DATA: if (tx_tick_end) begin
          tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
          tx_bit_reg <= tx_bit_reg + 3'h1;
          if (tx_bit_reg == last_bit) begin
            tx_phase_reg <= has_par ? UTR_PARITY : UTR_STOP;
            serial_out_pin <= has_par ? tx_par_reg : 1'b1;
            tx_stop_cnt_reg <= 1'b0;
          end else begin
            serial_out_pin <= tx_shift_reg[1];
          end
        end
        UTR_PARITY: if (tx_tick_end) begin
          tx_phase_reg <= UTR_STOP;
          serial_out_pin <= 1'b1;
        end
        UTR_STOP: begin
          if (tx_tick_end) tx_stop_cnt_reg <= 1'b1;
          if (tx_last_stop) begin
            tx_phase_reg <= UTR_IDLE;
            tx_done_irq <= 1'b1;
            // RULE_06 flags clear when nothing pending
            // RULE_02 inactive once complete
            tx_shift_active_flag_reg <= tx_buffer_full_flag_reg | wr_txb;
          end
        end
        default: tx_phase_reg <= UTR_IDLE;
      endcase
    end
  end

  // RULE_21 two-sample noise filter
  // RULE_22 up to two clocks delay
  logic rx_samp_reg, rx_filt_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_samp_reg <= 1'b1;
      rx_filt_reg <= 1'b1;
    end else begin
      rx_samp_reg <= serial_in_pin;
      if (rx_samp_reg == serial_in_pin) rx_filt_reg <= rx_samp_reg;
    end
  end

  // Receiver
  utr_phase_type rx_phase_reg;
  logic [8:0] rx_tick_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;
  logic rx_par_reg;
  wire rx_tick_end = (rx_tick_reg == ((rx_phase_reg == UTR_START) ? half_ticks : bit_ticks)
                      - 9'h1);
  // RULE_17 even check
  // RULE_18 odd check
  // RULE_19 zero parity unchecked
  // RULE_20 no parity unchecked
  // Seven-bit data sits in the upper bits of the shifter until it is aligned
  wire rx_ones = ^(len8 ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]}) ^ rx_par_reg;
  wire rx_par_bad = ((par_mode == UTR_PAR_EVEN) & rx_ones) |
                    ((par_mode == UTR_PAR_ODD) & ~rx_ones);
  wire rx_done = (rx_phase_reg == UTR_STOP) & rx_tick_end & rx_run;
  // RULE_16 error causes
  wire rx_ovr = rx_done & rx_unread_reg;
  wire rx_fe = rx_done & ~rx_filt_reg;
  wire rx_pe = rx_done & rx_par_bad;
  wire rx_any_err = rx_ovr | rx_fe | rx_pe;
  // RULE_24 seven-bit data: top bit zero
  wire [7:0] rx_byte = len8 ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_phase_reg <= UTR_IDLE;
      rx_tick_reg <= 9'h0;
      rx_bit_reg <= 3'h0;
      rx_shift_reg <= 8'h0;
      rx_par_reg <= 1'b0;
    end else if (!rx_run) begin
      // RULE_09 held idle
      // RULE_13 abort without effects
      rx_phase_reg <= UTR_IDLE;
      rx_tick_reg <= 9'h0;
    end else begin
      rx_tick_reg <= rx_tick_end ? 9'h0 : rx_tick_reg + 9'h1;
      unique case (rx_phase_reg)
        // RULE_08 hunt start bit
        UTR_IDLE: begin
          rx_tick_reg <= 9'h0;
          if (!rx_filt_reg) rx_phase_reg <= UTR_START;
        end
        UTR_START: if (rx_tick_end) begin
          rx_phase_reg <= rx_filt_reg ? UTR_IDLE : UTR_DATA;
          rx_bit_reg <= 3'h0;
        end
        UTR_DATA: if (rx_tick_end) begin
          rx_shift_reg <= {rx_filt_reg, rx_shift_reg[7:1]};
          rx_bit_reg <= rx_bit_reg + 3'h1;
          if (rx_bit_reg == last_bit) rx_phase_reg <= has_par ? UTR_PARITY : UTR_STOP;
        end
        UTR_PARITY: if (rx_tick_end) begin
          rx_par_reg <= rx_filt_reg;
          rx_phase_reg <= UTR_STOP;
        end
        UTR_STOP: if (rx_tick_end) rx_phase_reg <= UTR_IDLE;
        default: rx_phase_reg <= UTR_IDLE;
      endcase
    end
  end

  // Receive buffer, error flags and interrupts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_holding_buffer_reg <= UTR_RX_BUF_RST;
      rx_unread_reg <= 1'b0;
      parity_error_flag_reg <= 1'b0;
      framing_error_flag_reg <= 1'b0;
      overrun_error_flag_reg <= 1'b0;
      rx_done_irq <= 1'b0;
      rx_error_irq <= 1'b0;
    end else begin
      // RULE_15 read clears, set wins
      parity_error_flag_reg <= (parity_error_flag_reg & ~rd_err) | rx_pe;
      framing_error_flag_reg <= (framing_error_flag_reg & ~rd_err) | rx_fe;
      overrun_error_flag_reg <= (overrun_error_flag_reg & ~rd_err) | rx_ovr;
      // RULE_10 copy on stop
      // RULE_11 overrun keeps old byte
      // RULE_12 errored byte still copied
      if (rx_done && !rx_ovr) rx_holding_buffer_reg <= rx_byte;
      rx_unread_reg <= rx_done | (rx_unread_reg & ~rd_rxb);
      // RULE_14 merge select routes errors
      rx_done_irq <= rx_done & (~rx_any_err | error_irq_merge_select);
      rx_error_irq <= rx_done & rx_any_err & ~error_irq_merge_select;
    end
  end

endmodule : utr_core
`default_nettype wire

/* File: utr_core_assertions.sv */
// Checker for the serial channel, bound to utr_core.
// Assumes a divisor of 8 or more, so a bit lasts at least 16 clocks.
`default_nettype none
module utr_core_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Read channel
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Line and events
  input wire logic serial_out_pin,
  input wire logic tx_done_irq,
  input wire logic rx_done_irq,
  input wire logic rx_error_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Eight clocks of low level on the line, half the shortest legal bit
  sequence s_low_run;
    !serial_out_pin [*8];
  endsequence
  sequence s_quiet_rx;
    !(rx_done_irq || rx_error_irq) [*8];
  endsequence
  property p_bit_len;
    $fell(serial_out_pin) |=> s_low_run;
  endproperty
  a_bit_len: assert property (p_bit_len)
    else $error("low bit shorter than a bit time");
  property p_tx_stop;
    tx_done_irq |-> $past(serial_out_pin) && $past(serial_out_pin, 8);
  endproperty
  a_tx_stop: assert property (p_tx_stop)
    else $error("tx done not at end of stop bit");
  property p_tx_once;
    tx_done_irq |=> !tx_done_irq [*8];
  endproperty
  a_tx_once: assert property (p_tx_once)
    else $error("tx done repeated");
  property p_rx_one;
    rx_done_irq |-> !rx_error_irq;
  endproperty
  a_rx_one: assert property (p_rx_one)
    else $error("both receive events at once");
  property p_rx_gap;
    (rx_done_irq || rx_error_irq) |=> s_quiet_rx;
  endproperty
  a_rx_gap: assert property (p_rx_gap)
    else $error("receive event repeated");
  // Read answer timing and holding
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("address taken while answer pending");
endmodule // utr_core_assertions
bind utr_core utr_core_assertions u_chk (.clk, .reset_n, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .serial_out_pin, .tx_done_irq,
  .rx_done_irq, .rx_error_irq);
`default_nettype wire

/* File: utr_peer.sv */
// Remote serial peer: sends frames to the channel, decodes its output.
// Assumes BIT clocks per bit and a caller aligned to a rising edge.
`default_nettype none
module utr_peer
  import utr_pkg::*;
#(parameter int BIT = 16) (
  // Clock
  input wire logic clk,
  // Line from and to the channel
  input wire logic line_in,
  output var logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rxq[$];
  logic [8:0] f;
  int i;
  function automatic logic pbit(input logic [7:0] d, input logic [1:0] pm);
    return (pm == UTR_PAR_ZERO) ? 1'b0 : (^d) ^ (pm == UTR_PAR_ODD);
  endfunction
  initial begin
    forever begin
      @(negedge line_in);
      repeat (BIT / 2) @(posedge clk);
      if (!line_in) begin
        for (i = 0; i < 9; i++) begin
          repeat (BIT) @(posedge clk);
          f[i] = line_in;
        end
        rxq.push_back(f);
      end
    end
  end
  task automatic send(input logic [7:0] d, input logic [1:0] pm, input int nb,
                      input logic bad_par, input logic bad_stop);
    line_out <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int j = 0; j < nb; j++) begin
      line_out <= d[j];
      repeat (BIT) @(posedge clk);
    end
    if (pm != UTR_PAR_NONE) begin
      line_out <= pbit(d, pm) ^ bad_par;
      repeat (BIT) @(posedge clk);
    end
    line_out <= ~bad_stop;
    repeat (BIT) @(posedge clk);
    line_out <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  task automatic glitch();
    line_out <= 1'b0;
    @(posedge clk);
    line_out <= 1'b1;
  endtask
  initial line_out = 1'b1;
endmodule // utr_peer
`default_nettype wire

/* File: utr_pkg.sv */
// Package for the asynchronous serial transceiver channel.
// Assumes a 32-bit AXI4-Lite register bus and a single 100 MHz clock.
`default_nettype none
package utr_pkg;
  // Register byte offsets
  localparam logic [7:0] UTR_MODE_OFS = 8'h00;
  localparam logic [7:0] UTR_TX_STATUS_OFS = 8'h04;
  localparam logic [7:0] UTR_RX_ERR_OFS = 8'h08;
  localparam logic [7:0] UTR_TX_BUF_OFS = 8'h0c;
  localparam logic [7:0] UTR_RX_BUF_OFS = 8'h10;
  localparam logic [7:0] UTR_DIV_OFS = 8'h14;
  localparam logic [7:0] UTR_IRQ_OFS = 8'h18;
  // Mode control field positions
  localparam int UTR_MODE_UNIT_EN = 7;
  localparam int UTR_MODE_TX_EN = 6;
  localparam int UTR_MODE_RX_EN = 5;
  localparam int UTR_MODE_PAR_LO = 3;
  localparam int UTR_MODE_LEN8 = 2;
  localparam int UTR_MODE_STOP2 = 1;
  localparam int UTR_MODE_MERGE = 0;
  // Reset values
  localparam logic [7:0] UTR_MODE_RST = 8'h01;
  localparam logic [7:0] UTR_RX_BUF_RST = 8'hff;
  localparam logic [7:0] UTR_DIV_RST = 8'h08;
  // Baud clock: one bit is 2*k ticks of the base clock
  localparam int UTR_DIV_MIN = 8;
  // Parity modes
  localparam logic [1:0] UTR_PAR_NONE = 2'h0;
  localparam logic [1:0] UTR_PAR_ZERO = 2'h1;
  localparam logic [1:0] UTR_PAR_ODD = 2'h2;
  localparam logic [1:0] UTR_PAR_EVEN = 2'h3;
  // AXI responses
  localparam logic [1:0] UTR_RESP_OKAY = 2'h0;
  localparam logic [1:0] UTR_RESP_SLVERR = 2'h2;
  // Frame phases, one-hot
  typedef enum logic [4:0] {
    UTR_IDLE = 5'h01,
    UTR_START = 5'h02,
    UTR_DATA = 5'h04,
    UTR_PARITY = 5'h08,
    UTR_STOP = 5'h10
  } utr_phase_type;
endpackage : utr_pkg
`default_nettype wire
